// [pkg/csss_defines.svh]
// Offsets, field positions, reset values and cycle counts of the block.
`ifndef CSSS_DEFINES_SVH
`define CSSS_DEFINES_SVH
`define CSSS_OFF_TRIM 8'h00
`define CSSS_OFF_STATUS 8'h04
`define CSSS_TRIM_RANGE_BIT 7
`define CSSS_ST_SRC_LSB 0
`define CSSS_ST_XMODE_LSB 3
`define CSSS_ST_RUN_BIT 6
`define CSSS_ST_RSVD_BIT 7
`define CSSS_ST_SUT_LSB 8
`define CSSS_ST_FUSE_LSB 10
`define CSSS_FUSE_EXT 4'h0
`define CSSS_FUSE_RC8 4'h2
`define CSSS_FUSE_RC64 4'h3
`define CSSS_FUSE_LF 4'h6
`define CSSS_FUSE_DEFAULT 4'h2
`define CSSS_SUT_DEFAULT 2'h2
`define CSSS_CK_RST 16'h000e
`define CSSS_CK_WAKE_RC 16'h0006
`define CSSS_CK_WAKE_ONE 16'h0001
`define CSSS_CK_WAKE_258 16'h0102
`define CSSS_CK_WAKE_1K 16'h0400
`define CSSS_WDT_SHORT 16'h0200
`define CSSS_PLL_MULT_STD 4'h8
`define CSSS_PLL_MULT_COMPAT 4'h4
`endif

// [pkg/csss_pkg.sv]
// Types shared by the clock source and start-up selection block.
package csss_pkg;
  // Selected system clock source.
  typedef enum logic [2:0] {
    SRC_EXT, SRC_RC8, SRC_RC64, SRC_LF, SRC_XTAL, SRC_NONE
  } csss_src_t;
  // Extra reset timeout, counted on the watchdog oscillator.
  typedef enum logic [1:0] {TMO_NONE, TMO_SHORT, TMO_LONG} csss_tmo_t;
  // Configuration fuses as they arrive on the pins.
  typedef struct packed {
    logic [3:0] clock_source_fuses;
    logic [1:0] startup_time_fuses;
  } csss_fuse_t;
  // Decoded start-up configuration.
  typedef struct packed {
    csss_src_t src;
    logic [15:0] wake_ck;
    logic [15:0] rst_ck;
    csss_tmo_t tmo;
    logic rsvd;
  } csss_cfg_t;
  // Oscillator steering that leaves the block.
  typedef struct packed {
    csss_src_t src;
    logic [2:0] crystal_mode_fuses;
    logic rc_low_freq;
    logic [3:0] pll_mult;
  } csss_clkctl_t;
endpackage

// [src/csss_top.sv]
// Clock source selection, start-up timing and RC trim register.
`timescale 1ns/10ps
`default_nettype none
`include "csss_defines.svh"

module csss_top #(
  parameter logic [15:0] WAKE_16K = 16'd16384,
  parameter logic [15:0] WAKE_32K = 16'd32768,
  parameter logic [15:0] TMO_LONG_CYC = 16'd8192,
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fuses and factory calibration byte.
  input wire csss_pkg::csss_fuse_t fuses,
  input wire logic [7:0] cal_byte,
  // Oscillator cycle enables and sleep control.
  input wire logic src_tick,
  input wire logic wdt_tick,
  input wire logic sleep_req,
  input wire logic wake_req,
  // Clock steering and core gating.
  output csss_pkg::csss_clkctl_t clk_ctl,
  output logic [7:0] rc_oscillator_trim,
  output logic core_run,
  output logic wdt_osc_en,
  output logic cfg_reserved
);
  import csss_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decode of the fuse setting.

  // Maps the fuses onto source, wake count, reset count and timeout.
  function automatic csss_cfg_t decode(input csss_fuse_t f);
    csss_cfg_t c;
    logic [2:0] idx;
    c.src = SRC_NONE;
    c.wake_ck = `CSSS_CK_WAKE_RC;
    c.rst_ck = `CSSS_CK_RST;
    c.tmo = TMO_NONE;
    c.rsvd = 1'b0;
    idx = {f.clock_source_fuses[0], f.startup_time_fuses};
    if (f.clock_source_fuses[3]) begin
      // Crystal or resonator amplifier.
      c.src = SRC_XTAL;
      if (!idx[2]) begin
        // Group 0 wake counts.
        c.wake_ck = idx[1] ? `CSSS_CK_WAKE_1K : `CSSS_CK_WAKE_258;
      end else begin
        // Group 1 wake counts.
        c.wake_ck = (idx[1:0] == 2'h0) ? `CSSS_CK_WAKE_1K : WAKE_16K;
      end
      // Timeout repeats short, long, none over the combined code.
      case (idx)
        3'h0, 3'h3, 3'h6: c.tmo = TMO_SHORT;
        3'h1, 3'h4, 3'h7: c.tmo = TMO_LONG;
        default: c.tmo = TMO_NONE;
      endcase
    end else begin
      case (f.clock_source_fuses)
        `CSSS_FUSE_LF: begin
          // Watch crystal has no fixed reset cycles.
          c.src = SRC_LF;
          c.rst_ck = 16'h0000;
          c.wake_ck = `CSSS_CK_WAKE_1K;
          case (f.startup_time_fuses)
            2'h0: c.tmo = TMO_SHORT;
            2'h1: c.tmo = TMO_LONG;
            2'h2: begin
              c.tmo = TMO_LONG;
              c.wake_ck = WAKE_32K;
            end
            default: c.rsvd = 1'b1;
          endcase
        end
        `CSSS_FUSE_RC8, `CSSS_FUSE_EXT: begin
          // RC 8.0 MHz and external clock share one table.
          c.src = (f.clock_source_fuses == `CSSS_FUSE_RC8) ?
                  SRC_RC8 : SRC_EXT;
          case (f.startup_time_fuses)
            2'h0: c.tmo = TMO_NONE;
            2'h1: c.tmo = TMO_SHORT;
            2'h2: c.tmo = TMO_LONG;
            default: c.rsvd = 1'b1;
          endcase
        end
        `CSSS_FUSE_RC64: begin
          // Compatibility RC table.
          c.src = SRC_RC64;
          case (f.startup_time_fuses)
            2'h2: c.tmo = TMO_SHORT;
            2'h3: c.wake_ck = `CSSS_CK_WAKE_ONE;
            default: c.tmo = TMO_LONG;
          endcase
        end
        default: c.rsvd = 1'b1; // Reserved or unsupported code.
      endcase
    end
    c.src = c.rsvd ? SRC_NONE : c.src;
    return c;
  endfunction

  // Watchdog cycle count of a timeout code.
  function automatic logic [15:0] tmo_cycles(input csss_tmo_t t);
    case (t)
      TMO_SHORT: return `CSSS_WDT_SHORT;
      TMO_LONG: return TMO_LONG_CYC;
      default: return 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Fuse and calibration capture after reset release.

  // Low for the first cycle after reset, when straps are caught.
  logic loaded_q;
  // Fuses held for the whole run.
  csss_fuse_t fuses_q;
  // Decoded configuration of the held fuses and of the live fuse pins.
  csss_cfg_t cfg, cfg_in;
  assign cfg = decode(fuses_q);
  assign cfg_in = decode(fuses);

  // Catches fuses one cycle after release; reset value is the default.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
      fuses_q <= '{`CSSS_FUSE_DEFAULT, `CSSS_SUT_DEFAULT};
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      fuses_q <= fuses;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start-up sequencer.

  typedef enum {ST_LOAD, ST_RSTCK, ST_TMO, ST_RUN, ST_SLEEP, ST_WAKE,
                ST_HALT} csss_state_t;
  csss_state_t state_q, state_d;
  // Remaining ticks of the current wait.
  logic [15:0] cnt_q, cnt_d;

  // Next state: source cycles, then watchdog cycles, then run.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_LOAD: begin
        state_d = cfg_in.rsvd ? ST_HALT : ST_RSTCK;
        cnt_d = cfg_in.rst_ck;
      end
      ST_RSTCK: begin
        if (cnt_q == 16'h0000) begin
          state_d = ST_TMO;
          cnt_d = tmo_cycles(cfg.tmo);
        end else if (src_tick) begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      ST_TMO: begin
        // Counted on the watchdog oscillator whatever the source.
        if (cnt_q == 16'h0000) begin
          state_d = ST_RUN;
        end else if (wdt_tick) begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      ST_RUN: begin
        if (sleep_req) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_req) begin
          state_d = ST_WAKE;
          cnt_d = cfg.wake_ck;
        end
      end
      ST_WAKE: begin
        // Wake is timed by the selected source itself.
        if (cnt_q == 16'h0000) begin
          state_d = ST_RUN;
        end else if (src_tick) begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      ST_HALT: state_d = ST_HALT;
      default: state_d = ST_HALT;
    endcase
  end

  // Sequencer state and counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_LOAD;
      cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Core clock gate and status outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_run <= 1'b0;
      wdt_osc_en <= 1'b0;
      cfg_reserved <= 1'b0;
    end else begin
      core_run <= (state_d == ST_RUN);
      wdt_osc_en <= 1'b1;
      cfg_reserved <= cfg.rsvd & loaded_q;
    end
  end

  // Oscillator steering from the held fuses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctl <= '{SRC_NONE, 3'h0, 1'b0, `CSSS_PLL_MULT_STD};
    end else begin
      clk_ctl.src <= cfg.src;
      // Amplifier mode only while the crystal is chosen.
      clk_ctl.crystal_mode_fuses <= (cfg.src == SRC_XTAL) ?
                                    fuses_q.clock_source_fuses[3:1] : 3'h0;
      clk_ctl.rc_low_freq <= (cfg.src == SRC_RC64);
      clk_ctl.pll_mult <= (cfg.src == SRC_RC64) ?
                          `CSSS_PLL_MULT_COMPAT : `CSSS_PLL_MULT_STD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave and trim register.

  logic setup;
  logic wr_trim;
  assign setup = psel & penable & ~pready;
  assign wr_trim = setup & pwrite & (paddr == `CSSS_OFF_TRIM);

  // Trim: loaded from calibration each reset, fine field writable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_oscillator_trim <= 8'h00;
    end else if (!loaded_q) begin
      rc_oscillator_trim <= cal_byte;
    end else if (wr_trim) begin
      // Range bit is read only; fine field steps frequency.
      rc_oscillator_trim[6:0] <= pwdata[6:0];
    end
  end

  // One wait state: answer in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & (paddr != `CSSS_OFF_TRIM) &
                 (paddr != `CSSS_OFF_STATUS);
      prdata <= 32'h0000_0000;
      if (setup & ~pwrite & (paddr == `CSSS_OFF_TRIM)) begin
        prdata <= {24'h00_0000, rc_oscillator_trim};
      end else if (setup & ~pwrite & (paddr == `CSSS_OFF_STATUS)) begin
        prdata[`CSSS_ST_SRC_LSB +: 3] <= clk_ctl.src;
        prdata[`CSSS_ST_XMODE_LSB +: 3] <= clk_ctl.crystal_mode_fuses;
        prdata[`CSSS_ST_RUN_BIT] <= core_run;
        prdata[`CSSS_ST_RSVD_BIT] <= cfg_reserved;
        prdata[`CSSS_ST_SUT_LSB +: 2] <= fuses_q.startup_time_fuses;
        prdata[`CSSS_ST_FUSE_LSB +: 4] <= fuses_q.clock_source_fuses;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  a_trim_cal_load: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(loaded_q) |-> rc_oscillator_trim == $past(cal_byte))
    else $error("trim not loaded from calibration byte");
  a_trim_range_ro: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && wr_trim |=> rc_oscillator_trim[7] ==
    $past(rc_oscillator_trim[7]))
    else $error("trim range bit changed by a write");
  a_trim_fine_wr: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && wr_trim |=> rc_oscillator_trim[6:0] ==
    $past(pwdata[6:0]))
    else $error("trim fine field not written");
  a_xtal_mode_out: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && fuses_q.clock_source_fuses[3] |=>
    clk_ctl.crystal_mode_fuses == $past(fuses_q.clock_source_fuses[3:1]))
    else $error("crystal mode not driven from fuses");
  a_lf_select: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && fuses_q == {`CSSS_FUSE_LF, 2'h0} |=>
    clk_ctl.src == SRC_LF)
    else $error("low-frequency crystal not selected");
  a_rc8_select: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && fuses_q.clock_source_fuses == `CSSS_FUSE_RC8 &&
    fuses_q.startup_time_fuses != 2'h3 |=>
    clk_ctl.src == SRC_RC8 && !clk_ctl.rc_low_freq)
    else $error("RC 8.0 not selected");
  a_compat_pll: assert property (@(posedge pclk) disable iff (!presetn)
    fuses_q.clock_source_fuses == `CSSS_FUSE_RC64 |=>
    clk_ctl.pll_mult == `CSSS_PLL_MULT_COMPAT && clk_ctl.rc_low_freq)
    else $error("compatibility PLL factor wrong");
  a_ext_select: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && fuses_q == {`CSSS_FUSE_EXT, 2'h1} |=>
    clk_ctl.src == SRC_EXT)
    else $error("external clock not selected");
  a_core_gated: assert property (@(posedge pclk) disable iff (!presetn)
    state_q inside {ST_RSTCK, ST_TMO, ST_WAKE} && cnt_q != 16'h0000 |=>
    !core_run)
    else $error("core released before start-up done");
  a_tmo_wdt_only: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_TMO && !wdt_tick && cnt_q != 16'h0000 |=>
    cnt_q == $past(cnt_q))
    else $error("timeout counted without watchdog tick");
  a_wake_src_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_q == ST_WAKE && !src_tick && cnt_q != 16'h0000 |=>
    cnt_q == $past(cnt_q)) else $error("wake counted without source tick");
  a_wake_count: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_SLEEP && wake_req |=>
    state_q == ST_WAKE && cnt_q == $past(cfg.wake_ck))
    else $error("wake count not loaded");
  a_wdt_enabled: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q |-> wdt_osc_en)
    else $error("watchdog oscillator off");
endmodule
`default_nettype wire

// [verif/csss_top_bench.sv]
// Self-checking bench of the clock source and start-up selection block.
`timescale 1ns/10ps
`default_nettype none

module csss_top_bench;
  import csss_pkg::*;
  // One start-up case: fuses, source, crystal mode, reserved flag, counts.
  typedef struct packed {
    logic [5:0] f;
    logic [2:0] src;
    logic [2:0] xm;
    logic rs;
    logic [15:0] wk;
    logic [15:0] n;
  } csss_row_t;
  localparam int NROW = 14;
  localparam int LIMIT = 20000;
  // Bench-driven inputs and observed outputs.
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  csss_fuse_t fuses;
  logic [7:0] cal_byte;
  logic sleep_req, wake_req;
  // Oscillator enables; the source one runs at half rate under slow_src.
  logic src_tick = 1'b1;
  logic wdt_tick = 1'b0;
  logic slow_src = 1'b0;
  csss_clkctl_t clk_ctl;
  logic [7:0] rc_oscillator_trim;
  logic core_run, wdt_osc_en, cfg_reserved;
  // Counters, the case table and the last bus answer.
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  int w;
  csss_row_t rows [NROW];
  logic [31:0] rd;
  logic er;

  // Long counts are shortened so the run stays brief.
  csss_top #(.WAKE_16K(16'd20), .WAKE_32K(16'd40), .TMO_LONG_CYC(16'd16),
    .ADDR_W(8)) csss_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fuses(fuses),
    .cal_byte(cal_byte), .src_tick(src_tick), .wdt_tick(wdt_tick),
    .sleep_req(sleep_req), .wake_req(wake_req), .clk_ctl(clk_ctl),
    .rc_oscillator_trim(rc_oscillator_trim), .core_run(core_run),
    .wdt_osc_en(wdt_osc_en), .cfg_reserved(cfg_reserved));

  // The clock runs at 20 MHz.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The watchdog tick comes every second cycle, so its counts show twice.
  // The source tick is steady unless a case asks for a half-rate source.
  always @(posedge pclk) begin
    wdt_tick <= ~wdt_tick;
    src_tick <= slow_src ? ~src_tick : 1'b1;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      finish_test();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compares one value exactly, so an unknown never matches.
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Checks that a measured cycle count lies in its window.
  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int got);
    check_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high or 40 cycles pass.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    chk("pready", 32'h1, 32'(pready));
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Resets with one case's fuses and counts cycles until the core runs.
  task automatic start(input int i);
    @(posedge pclk);
    presetn <= 1'b0;
    fuses <= csss_fuse_t'(rows[i].f);
    cal_byte <= 8'ha5 ^ 8'(i * 37);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (core_run !== 1'b1 && n < (rows[i].rs ? 200 : 1200)) begin
      @(posedge pclk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: every case is reset into; non-reserved cases are also timed, slept and woken.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fuses = '0;
    cal_byte = 8'h00;
    sleep_req = 1'b0;
    wake_req = 1'b0;
    // Reset counts assume one source tick a cycle, two cycles a wdt tick.
    rows = '{'{6'h0a, 3'h1, 3'h0, 1'b0, 16'd6, 16'd46},
             '{6'h0f, 3'h2, 3'h0, 1'b0, 16'd1, 16'd14},
             '{6'h0c, 3'h2, 3'h0, 1'b0, 16'd6, 16'd46},
             '{6'h01, 3'h0, 3'h0, 1'b0, 16'd6, 16'd1038},
             '{6'h1a, 3'h3, 3'h0, 1'b0, 16'd40, 16'd32},
             '{6'h20, 3'h4, 3'h4, 1'b0, 16'd258, 16'd1038},
             '{6'h2d, 3'h4, 3'h5, 1'b0, 16'd20, 16'd14},
             '{6'h3c, 3'h4, 3'h7, 1'b0, 16'd1024, 16'd46},
             '{6'h33, 3'h4, 3'h6, 1'b0, 16'd1024, 16'd1038},
             '{6'h08, 3'h1, 3'h0, 1'b0, 16'd6, 16'd14},
             '{6'h14, 3'h0, 3'h0, 1'b1, 16'd0, 16'd0},
             '{6'h1b, 3'h0, 3'h0, 1'b1, 16'd0, 16'd0},
             '{6'h0b, 3'h0, 3'h0, 1'b1, 16'd0, 16'd0},
             '{6'h1c, 3'h0, 3'h0, 1'b1, 16'd0, 16'd0}};
    for (int i = 0; i < NROW; i++) begin
      start(i);
      chk("wdt_osc_en", 32'h1, 32'(wdt_osc_en));
      chk("trim load", 32'(cal_byte), 32'(rc_oscillator_trim));
      if (rows[i].rs) begin
        // A reserved code never lets the core run.
        chk("core_run", 32'h0, 32'(core_run));
        chk("cfg_reserved", 32'h1, 32'(cfg_reserved));
      end else begin
        chk_rng("reset delay", int'(rows[i].n) - 2, int'(rows[i].n) + 6,
                n);
        chk("src", 32'(rows[i].src), 32'(clk_ctl.src));
        chk("xtal mode", 32'(rows[i].xm),
            32'(clk_ctl.crystal_mode_fuses));
        chk("pll mult", (rows[i].f[5:2] == 4'h3) ? 32'h4 : 32'h8,
            32'(clk_ctl.pll_mult));
        chk("rc low", 32'(rows[i].f[5:2] == 4'h3),
            32'(clk_ctl.rc_low_freq));
        apb(1'b0, 8'h04, 32'h0);
        chk("status", {18'h0, rows[i].f, 1'b0, 1'b1, rows[i].xm,
            rows[i].src}, rd);
        if (i == 0) begin
          // Only the fine field is writable; the range bit stays loaded.
          // No nonvolatile write runs here, so any trim is allowed.
          // Each write moves the fine field by 0x20 at most.
          apb(1'b1, 8'h00, 32'h45);
          apb(1'b0, 8'h00, 32'h0);
          chk("trim", {24'h0, cal_byte[7], 7'h45}, rd);
          apb(1'b1, 8'h00, 32'h65);
          apb(1'b1, 8'h00, 32'hff);
          apb(1'b0, 8'h00, 32'h0);
          chk("trim", {24'h0, cal_byte[7], 7'h7f}, rd);
          // Walk back down in steps of 0x20 before the final zero.
          for (int v = 32'h5f; v >= 0; v -= 32'h20) begin
            apb(1'b1, 8'h00, 32'(v));
          end
          apb(1'b1, 8'h00, 32'h0);
          chk("trim pin", 32'({cal_byte[7], 7'h00}),
              32'(rc_oscillator_trim));
          // A write to the status word is ignored without an error.
          apb(1'b1, 8'h04, 32'hffff_ffff);
          chk("status err", 32'h0, 32'(er));
          apb(1'b0, 8'h04, 32'h0);
          chk("status", {18'h0, rows[i].f, 1'b0, 1'b1, rows[i].xm,
              rows[i].src}, rd);
          // An unmapped word answers with an error.
          apb(1'b0, 8'h08, 32'h0);
          chk("pslverr", 32'h1, 32'(er));
        end
        // Sleep, then wake and time the source start-up count.
        @(posedge pclk);
        sleep_req <= 1'b1;
        @(posedge pclk);
        sleep_req <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("core_run", 32'h0, 32'(core_run));
        // Odd cases wake on a half-rate source, so ticks gate the count.
        slow_src <= 1'(i % 2);
        wake_req <= 1'b1;
        @(posedge pclk);
        wake_req <= 1'b0;
        n = 0;
        w = int'(rows[i].wk) * (1 + i % 2);
        while (core_run !== 1'b1 && n < 2200) begin
          @(posedge pclk);
          n++;
        end
        slow_src <= 1'b0;
        chk_rng("wake count", w - 1, w + 5,
                n);
      end
    end
    finish_test();
  end
endmodule

`default_nettype wire
